// ==== src/uep_endpoint.sv ====
/*
  One endpoint: configuration, allocation check, byte count, banks.
  Assumes single-cycle event strobes from the controller core.
*/
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "uep_defs.svh"

module uep_endpoint #(
  parameter bit IS_EP0 = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic bus_reset_i,
  input wire logic cfg_we_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic fifo_clear_i,
  input wire logic sw_byte_i,
  input wire logic usb_byte_i,
  input wire logic setup_i,
  input wire logic setup_in_i,
  input wire logic toggle_err_i,
  input wire logic stall_i,
  input wire logic error_i,
  input wire logic hb_iso_i,
  input wire logic [1:0] int_en_i,
  output logic [31:0] cfg_o,
  output logic [31:0] sta_o,
  output logic int_o
);
  import uep_pkg::*;

  logic [31:0] cfg_r, cfg_nxt;
  uep_bcnt_t cnt_r, cnt_nxt;
  uep_bank_t bank_r, bank_nxt, busy_r, busy_nxt;
  uep_bank_t busy_step;
  logic ok_r, ok_nxt, dir_r, dir_nxt, terr_r, terr_nxt;
  logic [2:0] dly_r, dly_nxt;
  logic [15:0] bsize;
  logic [1:0] nbanks;
  logic in_ep, full, allowed;
  uep_kind_t kind;

  assign kind = uep_kind_t'(cfg_r[`UEP_CFG_TYPE_LO +: 2]);
  assign in_ep = cfg_r[`UEP_CFG_DIR] && kind != UEP_KIND_CTRL;
  assign bsize = 16'h0008 << cfg_r[`UEP_CFG_SIZE_LO +: 3];
  assign nbanks = cfg_r[`UEP_CFG_BK_LO +: 2] + 2'h1;
  assign full = {5'h0, cnt_r} >= bsize;
  assign allowed = !stall_i && !error_i && (in_ep ? !full : cnt_r != 11'h0);
  // A released IN bank waits for the host; a released OUT bank is free again
  assign busy_step = in_ep ? ((busy_r < nbanks) ? busy_r + 2'h1 : busy_r)
                           : ((busy_r != 2'h0) ? busy_r - 2'h1 : busy_r);

  always_comb begin
    cfg_nxt = cfg_r;
    ok_nxt = ok_r;
    cnt_nxt = cnt_r;
    bank_nxt = bank_r;
    busy_nxt = busy_r;
    dly_nxt = dly_r;
    dir_nxt = dir_r;
    terr_nxt = terr_r;
    if (cfg_we_i) begin
      cfg_nxt = {16'h0, 1'b0, cfg_wdata_i[14:8], 1'b0, cfg_wdata_i[6:2], cfg_wdata_i[1], 1'b0};
      if (cfg_wdata_i[`UEP_CFG_MEMORY_ALLOCATE]) begin
        ok_nxt = cfg_wdata_i[3:2] != 2'h3 && cfg_wdata_i[6:4] != 3'h7
          && ((16'h0008 << cfg_wdata_i[6:4]) * ({14'h0, cfg_wdata_i[3:2]} + 16'h1))
             <= `UEP_EP_MAX_BYTES
          && `UEP_EP_MAX_BYTES <= `UEP_DPRAM_BYTES;
      end
    end
    if (in_ep) begin
      cnt_nxt = cnt_r + {10'h0, sw_byte_i} - {10'h0, usb_byte_i};
    end else begin
      cnt_nxt = cnt_r + {10'h0, usb_byte_i} - {10'h0, sw_byte_i};
    end
    if (setup_i) begin
      dir_nxt = setup_in_i;
    end
    if (toggle_err_i && hb_iso_i && !in_ep) begin
      terr_nxt = 1'b1;
    end
    if (dly_r != 3'h0) begin
      dly_nxt = dly_r - 3'h1;
      if (dly_r == 3'h1) begin
        busy_nxt = busy_step;
      end
    end
    if (fifo_clear_i) begin
      cnt_nxt = 11'h0;
      dly_nxt = `UEP_NBUSY_DELAY;
      // A release still waiting would be lost by the restart: apply it now
      if (dly_r > 3'h1) begin
        busy_nxt = busy_step;
      end
      if (!(toggle_err_i && hb_iso_i)) begin
        terr_nxt = 1'b0;
      end
      if (kind != UEP_KIND_CTRL && nbanks != 2'h1) begin
        bank_nxt = (bank_r + 2'h1 >= nbanks) ? 2'h0 : bank_r + 2'h1;
      end
    end
    if (!in_ep && usb_byte_i == 1'b0 && full && busy_r == 2'h0) begin
      busy_nxt = 2'h1;
    end
    if (bus_reset_i) begin
      cfg_nxt[14:8] = 7'h0;
      if (!IS_EP0) begin
        cfg_nxt[6:1] = 6'h0;
      end
      cnt_nxt = 11'h0;
      bank_nxt = 2'h0;
      busy_nxt = 2'h0;
      dly_nxt = 3'h0;
      terr_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_r <= 32'h0;
      ok_r <= 1'b0;
      cnt_r <= 11'h0;
      bank_r <= 2'h0;
      busy_r <= 2'h0;
      dly_r <= 3'h0;
      dir_r <= 1'b0;
      terr_r <= 1'b0;
    end else if (en_i) begin
      cfg_r <= cfg_nxt;
      ok_r <= ok_nxt;
      cnt_r <= cnt_nxt;
      bank_r <= bank_nxt;
      busy_r <= busy_nxt;
      dly_r <= dly_nxt;
      dir_r <= dir_nxt;
      terr_r <= terr_nxt;
    end
  end

  // Count and bank are registered; allowed is decoded from the registered count and the live stall and error inputs
  assign cfg_o = cfg_r;
  assign sta_o = {1'b0, cnt_r, 1'b0, ok_r, dir_r, allowed, bank_r, busy_r, 1'b0, terr_r,
                  `UEP_DATA_TOGGLE_SEQ_RESET, 8'h0};
  assign int_o = (int_en_i[0] && (in_ep ? busy_r == 2'h0 : busy_r == nbanks))
                 || (int_en_i[1] && terr_r);

  a_byte_count_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && in_ep && sw_byte_i && !usb_byte_i && !fifo_clear_i && !bus_reset_i
    && !cfg_we_i |=> cnt_r == $past(cnt_r) + 11'h1)
    else $error("in count not incremented");
  a_byte_count_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !in_ep && usb_byte_i && !sw_byte_i && !fifo_clear_i && !bus_reset_i
    && !cfg_we_i |=> cnt_r == $past(cnt_r) + 11'h1)
    else $error("out count not incremented");
  a_ctrl_dir: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && setup_i |=> dir_r == $past(setup_in_i))
    else $error("control direction wrong");
  a_stall_block: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    stall_i || error_i |-> !sta_o[`UEP_STA_ACCESS_ALLOWED])
    else $error("access allowed while stalled");
  a_reset_ep0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && bus_reset_i |=> cfg_r[14:8] == 7'h0
    && (IS_EP0 || cfg_r[6:1] == 6'h0))
    else $error("bus reset clear wrong");
  a_terr_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && fifo_clear_i && !toggle_err_i |=> !terr_r)
    else $error("toggle error not cleared");
  a_reserved_bank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    bank_r != 2'h3)
    else $error("reserved bank code");
  a_sta_ro: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && !bus_reset_i && !setup_i && !toggle_err_i && !fifo_clear_i && dly_r == 3'h0
    |=> terr_r == $past(terr_r) && dir_r == $past(dir_r))
    else $error("status changed without cause");

  sequence s_bank_release;
    en_i && fifo_clear_i && !bus_reset_i;
  endsequence
  sequence s_quiet_step;
    en_i && !fifo_clear_i && !bus_reset_i;
  endsequence
  a_busy_delay: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_bank_release |=> dly_r == `UEP_NBUSY_DELAY)
    else $error("busy update delay not started");
  a_busy_step: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_bank_release ##1 s_quiet_step |=> dly_r == 3'h1)
    else $error("busy update delay not counting");
endmodule : uep_endpoint
`default_nettype wire

// ==== include/uep_defs.svh ====
/*
  Offsets, field positions, reset values and timing counts of the
  endpoint configuration and status block.
  Assumes a word-addressed register port with byte offsets.
*/
`ifndef UEP_DEFS_SVH
`define UEP_DEFS_SVH

`define UEP_NUM_EP 8
`define UEP_CFG_BASE 12'h100
`define UEP_STA_BASE 12'h130
`define UEP_FIFOCLR_OFS 12'h160
`define UEP_EVT_OFS 12'h164
`define UEP_INTEN_OFS 12'h168
`define UEP_STA_RESET 32'h0000_0100
`define UEP_DATA_TOGGLE_SEQ_RESET 2'h1
`define UEP_DPRAM_BYTES 16'h1000
`define UEP_EP_MAX_BYTES 16'h0400
`define UEP_CFG_MEMORY_ALLOCATE 1
`define UEP_CFG_BK_LO 2
`define UEP_CFG_SIZE_LO 4
`define UEP_CFG_DIR 8
`define UEP_CFG_AUTO_BANK_SWITCH 9
`define UEP_CFG_TYPE_LO 11
`define UEP_STA_DATA_TOGGLE_SEQ_LO 8
`define UEP_STA_TERR 10
`define UEP_STA_NBUSY_LO 12
`define UEP_STA_CURR_LO 14
`define UEP_STA_ACCESS_ALLOWED 16
`define UEP_STA_CONTROL_NEXT_DIRECTION 17
`define UEP_STA_CONFIG_VALID 18
`define UEP_STA_FIFO_BYTE_COUNT_LO 20
`define UEP_NBUSY_DELAY 3'h2

`endif

// ==== include/uep_pkg.sv ====
/*
  Types of the endpoint configuration and status block.
  Assumes uep_defs.svh is on the include path.
*/
package uep_pkg;
  typedef enum logic [1:0] {
    UEP_KIND_CTRL,
    UEP_KIND_ISO,
    UEP_KIND_BULK,
    UEP_KIND_INTR
  } uep_kind_t;
  typedef logic [10:0] uep_bcnt_t;
  typedef logic [1:0] uep_bank_t;
endpackage : uep_pkg

// ==== src/uep_top.sv ====
/*
  Register port and eight endpoint configuration and status slices.
  Assumes a strobed register master and controller event strobes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uep_defs.svh"


module uep_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic bus_reset_i,
  input wire logic [7:0] usb_byte_i,
  input wire logic [7:0] sw_byte_i,
  input wire logic [7:0] setup_i,
  input wire logic setup_in_i,
  input wire logic [7:0] toggle_err_i,
  input wire logic [7:0] stall_i,
  input wire logic [7:0] error_i,
  output logic [7:0] endpoint_interrupt_o
);
  import uep_pkg::*;

  logic [31:0] cfg_w [8];
  logic [31:0] sta_w [8];
  logic [15:0] inten_r, inten_nxt;
  logic [7:0] hbiso_r, hbiso_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] clr;

  assign clr = (wr_i && addr_i == `UEP_FIFOCLR_OFS) ? wdata_i[7:0] : 8'h0;

  for (genvar n = 0; n < 8; n++) begin : g_ep
    uep_endpoint #(.IS_EP0(n == 0)) u_ep (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .en_i(en_i),
      .bus_reset_i(bus_reset_i),
      .cfg_we_i(wr_i && addr_i == `UEP_CFG_BASE + 12'(n * 4)),
      .cfg_wdata_i(wdata_i),
      .fifo_clear_i(clr[n]),
      .sw_byte_i(sw_byte_i[n]),
      .usb_byte_i(usb_byte_i[n]),
      .setup_i(setup_i[n]),
      .setup_in_i(setup_in_i),
      .toggle_err_i(toggle_err_i[n]),
      .stall_i(stall_i[n]),
      .error_i(error_i[n]),
      .hb_iso_i(hbiso_r[n]),
      .int_en_i(inten_r[2*n +: 2]),
      .cfg_o(cfg_w[n]),
      .sta_o(sta_w[n]),
      .int_o(endpoint_interrupt_o[n])
    );
  end

  always_comb begin
    inten_nxt = inten_r;
    hbiso_nxt = hbiso_r;
    rdata_nxt = 32'h0;
    if (wr_i && addr_i == `UEP_INTEN_OFS) begin
      inten_nxt = wdata_i[15:0];
    end
    if (wr_i && addr_i == `UEP_EVT_OFS) begin
      hbiso_nxt = wdata_i[7:0];
    end
    if (rd_i) begin
      for (int i = 0; i < 8; i++) begin
        if (addr_i == `UEP_CFG_BASE + 12'(i * 4)) begin
          rdata_nxt = cfg_w[i];
        end
        if (addr_i == `UEP_STA_BASE + 12'(i * 4)) begin
          rdata_nxt = sta_w[i];
        end
      end
      if (addr_i == `UEP_INTEN_OFS) begin
        rdata_nxt = {16'h0, inten_r};
      end
      if (addr_i == `UEP_EVT_OFS) begin
        rdata_nxt = {24'h0, hbiso_r};
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      inten_r <= 16'h0;
      hbiso_r <= 8'h0;
      rdata_r <= 32'h0;
    end else if (en_i) begin
      inten_r <= inten_nxt;
      hbiso_r <= hbiso_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  a_read_lat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    en_i && rd_i && addr_i == `UEP_INTEN_OFS && !wr_i |=> rdata_o == {16'h0, inten_r})
    else $error("read data wrong");
endmodule : uep_top
`default_nettype wire

// ==== verification/uep_host_model.sv ====
/*
  Host side of the USB bus: byte, setup and toggle error strobes.
  Assumes the clock of the block; strobes move after its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module uep_host_model (
  input wire logic clk_i,
  output logic [7:0] byte_o,
  output logic [7:0] setup_o,
  output logic setup_in_o,
  output logic [7:0] terr_o
);
  // ********************
  // Strobe tasks
  // ********************
  initial begin
    byte_o = '0;
    setup_o = '0;
    setup_in_o = 1'b0;
    terr_o = '0;
  end

  // One byte a cycle for n cycles
  task automatic send(input int ep, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      byte_o <= 8'h01 << ep;
    end
    @(posedge clk_i);
    byte_o <= '0;
  endtask : send

  task automatic setup(input int ep, input logic dir);
    @(posedge clk_i);
    setup_o <= 8'h01 << ep;
    setup_in_o <= dir;
    @(posedge clk_i);
    setup_o <= '0;
    setup_in_o <= ~dir;
  endtask : setup

  task automatic terr(input int ep);
    @(posedge clk_i);
    terr_o <= 8'h01 << ep;
    @(posedge clk_i);
    terr_o <= '0;
  endtask : terr
endmodule : uep_host_model

`default_nettype wire

// ==== verification/uep_top_tb.sv ====
/*
  Self-checking bench of the endpoint configuration and status block.
  Assumes uep_host_model and uep_defs.svh on the include path.
*/
`timescale 1ns/1ps
`default_nettype none

module uep_top_tb;
  import uep_pkg::*;
  // ********************
  // Bench
  // ********************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] addr_i = '0;
  logic [31:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic en_i = 1'b1;
  logic bus_reset_i = 1'b0;
  logic [7:0] sw_byte_i = '0;
  logic [7:0] stall_i = '0;
  logic [7:0] error_i = '0;
  logic [31:0] rdata_o;
  logic [7:0] usb_b, setup, terr, endpoint_interrupt_o;
  logic setup_in;
  logic [31:0] cv [8];
  logic [31:0] s, c;
  int miscompares = 0;
  int tests_run = 0;
  int k, m;

  always #5 clk_i = ~clk_i;

  uep_top i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .en_i(en_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bus_reset_i(bus_reset_i), .usb_byte_i(usb_b), .sw_byte_i(sw_byte_i),
    .setup_i(setup), .setup_in_i(setup_in), .toggle_err_i(terr), .stall_i(stall_i),
    .error_i(error_i), .endpoint_interrupt_o(endpoint_interrupt_o));
  uep_host_model i_host (.clk_i(clk_i), .byte_o(usb_b), .setup_o(setup),
    .setup_in_o(setup_in), .terr_o(terr));

  function automatic logic [11:0] cfga(input int n);
    return 12'h100 + 12'(4 * n);
  endfunction : cfga
  function automatic logic [11:0] staa(input int n);
    return 12'h130 + 12'(4 * n);
  endfunction : staa
  function automatic logic ok_f(input logic [31:0] v);
    return v[3:2] != 2'h3 && v[6:4] != 3'h7 && (8 << v[6:4]) * (int'(v[3:2]) + 1) <= 1024;
  endfunction : ok_f

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task automatic swb(input int ep, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      sw_byte_i <= 8'h01 << ep;
    end
    @(posedge clk_i);
    sw_byte_i <= '0;
  endtask : swb
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end

  initial begin
    c = $urandom(32'h4781f936);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int n = 0; n < 8; n++) begin
      rd(staa(n), s);
      chk(s, 32'h0000_0100);
      rd(cfga(n), s);
      chk(s, 32'h0);
    end
    for (int n = 0; n < 8; n++) begin
      c = ($urandom & 32'h7b7e) | 32'h2;
      if (c[12:11] == 2'h0) c[3:2] = 2'h0;
      // Largest bank with three and with the reserved count
      if (n > 5) c = 32'h0000_1066 + 32'(4 * (n - 5));
      cv[n] = c;
      wr(cfga(n), c);
      rd(cfga(n), s);
      chk(s, c);
      rd(staa(n), s);
      chk(32'(s[18]), 32'(ok_f(c)));
      wr(staa(n), $urandom);
      rd(staa(n), c);
      chk(c, s);
    end
    wr(cfga(7), 32'h0000_1066);
    rd(staa(7), s);
    chk(32'(s[18]), 32'h1);
    wr(cfga(2), 32'h0000_0836);
    wr(cfga(3), 32'h0000_1136);
    k = $urandom_range(20, 2);
    m = $urandom_range(k - 1, 1);
    i_host.send(2, k);
    swb(2, m);
    rd(staa(2), s);
    chk(32'(s[30:20]), 32'(k - m));
    chk(32'(s[16]), 32'h1);
    for (int j = 1; j < 3; j++) begin
      @(posedge clk_i);
      {error_i[2], stall_i[2]} <= 2'(j);
      rd(staa(2), s);
      chk(32'(s[16]), 32'h0);
    end
    @(posedge clk_i);
    {error_i[2], stall_i[2]} <= 2'h0;
    swb(3, k);
    i_host.send(3, m);
    rd(staa(3), s);
    chk(32'(s[30:20]), 32'(k - m));
    for (int j = 1; j >= 0; j--) begin
      i_host.setup(0, j[0]);
      rd(staa(0), s);
      chk(32'(s[17]), 32'(j));
    end
    wr(12'h164, 32'h4);
    wr(12'h168, 32'h20);
    i_host.terr(2);
    rd(staa(2), s);
    chk(32'(s[10]), 32'h1);
    chk(32'(endpoint_interrupt_o[2]), 32'h1);
    wr(12'h160, 32'h4);
    repeat (3) @(posedge clk_i);
    rd(staa(2), s);
    chk(s & 32'hfff0_f400, 32'h0000_4000);
    chk(32'(endpoint_interrupt_o[2]), 32'h0);
    wr(12'h168, 32'h50);
    rd(staa(3), s);
    chk(32'(endpoint_interrupt_o[3]), 32'h1);
    wr(12'h160, 32'h8);
    rd(staa(3), s);
    chk(32'(s[13:12]), 32'h0);
    rd(staa(3), s);
    chk(s & 32'hfff0_f000, 32'h0000_5000);
    chk(32'(endpoint_interrupt_o[3]), 32'h0);
    wr(cfga(2), 32'h0000_0802);
    i_host.send(2, 8);
    rd(staa(2), s);
    chk(32'(s[13:12]), 32'h1);
    chk(32'(endpoint_interrupt_o[2]), 32'h1);
    // Clock enable low: host bytes must not move the count
    @(posedge clk_i);
    en_i <= 1'b0;
    i_host.send(2, 3);
    @(posedge clk_i);
    en_i <= 1'b1;
    rd(staa(2), s);
    chk(32'(s[30:20]), 32'h8);
    @(posedge clk_i);
    bus_reset_i <= 1'b1;
    @(posedge clk_i);
    bus_reset_i <= 1'b0;
    for (int n = 0; n < 8; n++) begin
      rd(cfga(n), s);
      chk(s & 32'h1b7e, n == 0 ? cv[0] & 32'h7e : 32'h0);
    end
    rd(12'h200, s);
    chk(s, 32'h0);
    report_and_stop();
  end
endmodule : uep_top_tb

`default_nettype wire
